// >>> byte_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } fifo_state_type;
    fifo_state_type st;
    fifo_state_type next_st;
    logic push;
    logic pop;
    // Handshake decode; count is one bit wider than the pointers so full is visible
    assign in_ready_o = (st.count != (AW + 1)'(DEPTH));
    assign out_valid_o = (st.count != '0);
    assign out_data_o = st.mem[st.rd_ptr];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    // Pointer and storage update
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr_ptr] = in_data_i;
            next_st.wr_ptr = st.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_st.rd_ptr = st.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_st.count = st.count + 1'b1;
        end else if (pop && !push) begin
            next_st.count = st.count - 1'b1;
        end
    end
    // State register
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : byte_fifo
`default_nettype wire

// >>> far_serial_device.sv
// Far side serial device: async peer and mode 0 shift register
`timescale 1ns/1ps
`default_nettype none
module far_serial_device (
    input wire logic core_clk_i,
    input wire logic line_i,
    input wire logic serial_out_pin_i,
    output logic drive_o
);
    logic last_out = 1'b1;
    initial drive_o = 1'b1;
    // Previous level of the device output
    always @(posedge core_clk_i) last_out <= serial_out_pin_i;
    task automatic wait_edge(input logic lvl);
        do @(posedge core_clk_i); while (!(last_out === ~lvl && serial_out_pin_i === lvl));
    endtask : wait_edge
    // start, data LSB first, stop, idle
    task automatic send_async(input logic [7:0] d, input logic stop, input int len);
        logic [10:0] f;
        f = {1'b1, stop, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            drive_o <= f[i];
            repeat (len) @(posedge core_clk_i);
        end
    endtask : send_async
    // mid bit sampling of a frame
    task automatic recv_async(output logic [7:0] d, output logic stop, input int len);
        wait_edge(1'b0);
        repeat (len / 2) @(posedge core_clk_i);
        for (int i = 0; i < 9; i++) begin
            repeat (len) @(posedge core_clk_i);
            if (i < 8) d[i] = serial_out_pin_i;
            else stop = serial_out_pin_i;
        end
    endtask : recv_async
    // Bits change after each clock fall, open drain
    task automatic shift_sync(input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            wait_edge(1'b0);
            drive_o <= d[i];
        end
        repeat (14) @(posedge core_clk_i);
        drive_o <= 1'b1;
    endtask : shift_sync
    // Wire sampled at each clock rise
    task automatic capture_sync(output logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            wait_edge(1'b1);
            d[i] = line_i;
        end
    endtask : capture_sync
endmodule : far_serial_device
`default_nettype wire

// >>> serial_port.sv
// Serial port unit: synchronous shift mode and 8-bit asynchronous mode
`timescale 1ns/1ps
`default_nettype none
module serial_port
    import serial_port_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [1:0] mode_i,
    input wire logic rx_enable_bit_i,
    input wire logic multiproc_check_bit_i,
    input wire logic rate_double_bit_i,
    input wire logic [1:0] tx_rate_source_sel_i,
    input wire logic [1:0] rx_rate_source_sel_i,
    input wire logic [3:0] timer_overflow_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    input wire logic wr_valid_i,
    output logic wr_ready_o,
    input wire logic rd_strobe_i,
    input wire logic clr_tx_done_i,
    input wire logic clr_rx_done_i,
    input wire logic clr_overrun_i,
    input wire logic irq_enable_i,
    output logic [DATA_W-1:0] serial_data_buffer_o,
    output logic tx_done_flag_o,
    output logic rx_done_flag_o,
    output logic ninth_rx_bit_o,
    output logic overrun_o,
    output logic tx_busy_o,
    output logic irq_o,
    input wire logic serial_in_pin_i,
    output logic serial_in_pin_o,
    output logic serial_in_pin_oe_o,
    output logic serial_out_pin_o
);
    typedef struct packed {
        logic [1:0] in_sync;
        logic rx_prev;
        tx_state_type tx_st;
        rx_state_type rx_st;
        logic [DATA_W-1:0] tx_shift;
        logic [3:0] tx_bits;
        logic [3:0] tx_ovs;
        logic [DATA_W-1:0] rx_shift;
        logic [3:0] rx_bits;
        logic [3:0] rx_ovs;
        logic [3:0] sync_div;
        logic t1_half_tx;
        logic t1_half_rx;
        logic [DATA_W-1:0] rx_buffer;
        logic unread;
        logic tx_done;
        logic rx_done;
        logic ninth;
        logic overrun;
        logic out_pin;
        logic sclk;
        logic in_drive_low;
    } port_state_type;
    port_state_type st;
    port_state_type next_st;
    logic fifo_valid;
    logic fifo_pop;
    logic [DATA_W-1:0] fifo_data;
    logic rx_pin;
    logic tx_ovf;
    logic rx_ovf;
    logic tx_tick;
    logic rx_tick;
    logic sync_tick;
    logic rx_load;
    logic [DATA_W-1:0] rx_byte;
    logic tx_set;

    // Write data waits in the FIFO; transmitter pops when idle
    byte_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) tx_fifo (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .in_data_i(wr_data_i),
        .in_valid_i(wr_valid_i),
        .in_ready_o(wr_ready_o),
        .out_data_o(fifo_data),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop)
    );

    // Pin sampled after the two-stage synchroniser
    assign rx_pin = st.in_sync[1];
    assign tx_ovf = timer_overflow_i[tx_rate_source_sel_i];
    assign rx_ovf = timer_overflow_i[rx_rate_source_sel_i];
    assign tx_tick = tx_ovf && ((tx_rate_source_sel_i != SRC_TIMER1) || rate_double_bit_i
                     || st.t1_half_tx);
    assign rx_tick = rx_ovf && ((rx_rate_source_sel_i != SRC_TIMER1) || rate_double_bit_i
                     || st.t1_half_rx);
    assign sync_tick = (st.sync_div == MODE0_DIV_LAST);
    // nine-bit modes never start a frame; mode 1 stays full duplex
    assign fifo_pop = (st.tx_st == TX_IDLE) && fifo_valid
                      && ((mode_i == MODE_SYNC) ? (st.rx_st == RX_IDLE) : (mode_i == MODE_ASYNC8));
    assign rx_byte = {rx_pin, st.rx_shift[DATA_W-1:1]};

    // Outputs from the state register
    assign serial_data_buffer_o = st.rx_buffer;
    assign tx_done_flag_o = st.tx_done;
    assign rx_done_flag_o = st.rx_done;
    assign ninth_rx_bit_o = st.ninth;
    assign overrun_o = st.overrun;
    assign tx_busy_o = (st.tx_st != TX_IDLE);
    assign irq_o = irq_enable_i && (st.tx_done || st.rx_done);
    assign serial_out_pin_o = st.out_pin;
    assign serial_in_pin_o = 1'b0;
    assign serial_in_pin_oe_o = st.in_drive_low;

    // Next state of the whole port
    always_comb begin
        next_st = st;
        rx_load = 1'b0;
        tx_set = 1'b0;
        next_st.in_sync = {st.in_sync[0], serial_in_pin_i};
        next_st.rx_prev = rx_pin;
        next_st.sync_div = sync_tick ? '0 : st.sync_div + 1'b1;
        if (tx_ovf && tx_rate_source_sel_i == SRC_TIMER1) begin
            next_st.t1_half_tx = !st.t1_half_tx;
        end
        if (rx_ovf && rx_rate_source_sel_i == SRC_TIMER1) begin
            next_st.t1_half_rx = !st.t1_half_rx;
        end
        // Transmitter
        case (st.tx_st)
            TX_IDLE: begin
                // Output pin left alone: a mode 0 receive may own the clock
                next_st.in_drive_low = 1'b0;
                if (fifo_pop) begin
                    next_st.tx_shift = fifo_data;
                    next_st.tx_bits = '0;
                    next_st.tx_ovs = '0;
                    next_st.sync_div = '0;
                    if (mode_i == MODE_SYNC) begin
                        next_st.tx_st = TX_SYNC;
                        next_st.in_drive_low = !fifo_data[0];
                        // First bit also gets its low then high clock half
                        next_st.out_pin = 1'b0;
                    end else begin
                        next_st.tx_st = TX_ASYNC;
                        next_st.out_pin = 1'b0;
                    end
                end
            end
            TX_SYNC: begin
                // Clock low first half, high second half
                if (st.sync_div == MODE0_HALF) begin
                    next_st.out_pin = 1'b1;
                end
                if (sync_tick) begin
                    next_st.out_pin = 1'b0;
                    next_st.tx_shift = st.tx_shift >> 1;
                    next_st.in_drive_low = !st.tx_shift[1];
                    next_st.tx_bits = st.tx_bits + 1'b1;
                    if (st.tx_bits == BITS_LAST) begin
                        tx_set = 1'b1;
                        next_st.tx_st = TX_IDLE;
                        next_st.out_pin = 1'b1;
                        next_st.in_drive_low = 1'b0;
                    end
                end
            end
            TX_ASYNC: begin
                if (tx_tick) begin
                    next_st.tx_ovs = st.tx_ovs + 1'b1;
                    if (st.tx_ovs == OVS_LAST) begin
                        next_st.tx_bits = st.tx_bits + 1'b1;
                        if (st.tx_bits == BITS_LAST + 4'h1) begin
                            next_st.out_pin = 1'b1;
                            tx_set = 1'b1;
                            next_st.tx_st = TX_STOP;
                        end else begin
                            next_st.out_pin = st.tx_shift[0];
                            next_st.tx_shift = st.tx_shift >> 1;
                        end
                    end
                end
            end
            TX_STOP: begin
                if (tx_tick && st.tx_ovs == OVS_LAST) begin
                    next_st.tx_st = TX_IDLE;
                end else if (tx_tick) begin
                    next_st.tx_ovs = st.tx_ovs + 1'b1;
                end
            end
            default: begin
                next_st.tx_st = TX_IDLE;
            end
        endcase
        // Receiver
        case (st.rx_st)
            RX_IDLE: begin
                // mode 0 starts when enabled, flag clear, transmitter idle and nothing queued; mode 1 starts when enabled at a falling edge
                if (mode_i == MODE_SYNC && rx_enable_bit_i && !st.rx_done
                    && st.tx_st == TX_IDLE && !fifo_valid) begin
                    next_st.rx_st = RX_SYNC;
                    next_st.rx_bits = '0;
                    next_st.sync_div = '0;
                    next_st.out_pin = 1'b0;
                end else if (mode_i == MODE_ASYNC8 && rx_enable_bit_i && st.rx_prev
                             && !rx_pin) begin
                    next_st.rx_st = RX_ASYNC;
                    next_st.rx_bits = '0;
                    next_st.rx_ovs = '0;
                end
            end
            RX_SYNC: begin
                if (st.sync_div == MODE0_HALF) begin
                    next_st.out_pin = 1'b1;
                end
                if (sync_tick) begin
                    next_st.out_pin = 1'b0;
                    next_st.rx_shift = rx_byte;
                    next_st.rx_bits = st.rx_bits + 1'b1;
                    if (st.rx_bits == BITS_LAST) begin
                        next_st.out_pin = 1'b1;
                        next_st.rx_st = RX_HOLD;
                    end
                end
            end
            RX_HOLD: begin
                // flag one cycle after eighth bit
                rx_load = 1'b1;
                next_st.rx_buffer = st.rx_shift;
                next_st.rx_st = RX_IDLE;
            end
            RX_ASYNC: begin
                if (rx_tick) begin
                    next_st.rx_ovs = st.rx_ovs + 1'b1;
                    if (st.rx_ovs == OVS_MID) begin
                        next_st.rx_bits = st.rx_bits + 1'b1;
                        if (st.rx_bits == '0 && rx_pin) begin
                            next_st.rx_st = RX_IDLE;
                        end else if (st.rx_bits == ASYNC_BITS_LAST) begin
                            next_st.rx_st = RX_IDLE;
                            // load only if clear and check ok
                            if (!st.rx_done && (!multiproc_check_bit_i || rx_pin)) begin
                                rx_load = 1'b1;
                                next_st.rx_buffer = st.rx_shift;
                                next_st.ninth = rx_pin;
                            end
                        end else if (st.rx_bits != '0) begin
                            next_st.rx_shift = rx_byte;
                        end
                    end
                end
            end
            default: begin
                next_st.rx_st = RX_IDLE;
            end
        endcase
        if (clr_tx_done_i) begin
            next_st.tx_done = 1'b0;
        end
        if (tx_set) begin
            next_st.tx_done = 1'b1;
        end
        if (clr_rx_done_i) begin
            next_st.rx_done = 1'b0;
        end
        if (clr_overrun_i) begin
            next_st.overrun = 1'b0;
        end
        if (rd_strobe_i) begin
            next_st.unread = 1'b0;
        end
        if (rx_load) begin
            next_st.rx_done = 1'b1;
            next_st.unread = 1'b1;
            if (st.unread && !rd_strobe_i) begin
                next_st.overrun = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            st <= '{in_sync: 2'h3, rx_prev: 1'b1, tx_st: TX_IDLE, rx_st: RX_IDLE,
                    out_pin: 1'b1, default: '0};
        end else begin
            st <= next_st;
        end
    end
endmodule : serial_port
`default_nettype wire

// >>> serial_port_pkg.sv
// Constants and types shared by the serial port unit
package serial_port_pkg;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW = 4;
    // Serial control register bit positions
    localparam int RX_DONE_POS = 0;
    localparam int TX_DONE_POS = 1;
    localparam int NINTH_RX_POS = 2;
    localparam int RX_EN_POS = 4;
    localparam int MULTIPROC_POS = 5;
    // Serial status register bit positions
    localparam int RATE_DOUBLE_POS = 4;
    // Timing
    localparam int CORE_CLK_MHZ = 100;
    localparam int MODE0_DIV = 12;
    localparam logic [3:0] MODE0_DIV_LAST = 4'hb;
    localparam logic [3:0] MODE0_HALF = 4'h5;
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] OVS_MID = 4'h7;
    localparam logic [3:0] BITS_LAST = 4'h7;
    localparam logic [3:0] ASYNC_BITS_LAST = 4'h9;
    // Operating modes
    localparam logic [1:0] MODE_SYNC = 2'h0;
    localparam logic [1:0] MODE_ASYNC8 = 2'h1;
    localparam logic [1:0] MODE_FIXED9 = 2'h2;
    localparam logic [1:0] MODE_VAR9 = 2'h3;
    // Rate source codes
    localparam logic [1:0] SRC_TIMER1 = 2'h0;
    typedef enum logic [4:0] {
        TX_IDLE = 5'b00001,
        TX_SYNC = 5'b00010,
        TX_ASYNC = 5'b00100,
        TX_STOP = 5'b01000,
        TX_SPARE = 5'b10000
    } tx_state_type;
    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_SYNC = 4'b0010,
        RX_ASYNC = 4'b0100,
        RX_HOLD = 4'b1000
    } rx_state_type;
endpackage : serial_port_pkg

// >>> serial_port_props.sv
// Checker of the serial port unit, bound to its ports
`timescale 1ns/1ps
`default_nettype none
module serial_port_props
    import serial_port_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [1:0] mode_i,
    input wire logic multiproc_check_bit_i,
    input wire logic clr_tx_done_i,
    input wire logic clr_rx_done_i,
    input wire logic clr_overrun_i,
    input wire logic irq_enable_i,
    input wire logic [DATA_W-1:0] serial_data_buffer_o,
    input wire logic tx_done_flag_o,
    input wire logic rx_done_flag_o,
    input wire logic ninth_rx_bit_o,
    input wire logic overrun_o,
    input wire logic irq_o,
    input wire logic tx_busy_o,
    input wire logic serial_out_pin_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    // Halves of one shift clock period
    sequence low_half_s; (!serial_out_pin_o) [*6]; endsequence
    sequence high_half_s; serial_out_pin_o [*6]; endsequence
    a_irq_from_flags: assert property (irq_o == (irq_enable_i && (tx_done_flag_o || rx_done_flag_o)))
        else $error("irq does not follow the done flags");
    a_tx_done_held: assert property (tx_done_flag_o && !clr_tx_done_i |=> tx_done_flag_o)
        else $error("tx done lost without a clear");
    a_rx_done_held: assert property (rx_done_flag_o && !clr_rx_done_i |=> rx_done_flag_o)
        else $error("rx done lost without a clear");
    a_rx_buffer_held: assert property (rx_done_flag_o && !clr_rx_done_i |=> $stable(serial_data_buffer_o))
        else $error("buffer loaded while rx done set");
    a_overrun_held: assert property (overrun_o && !clr_overrun_i |=> overrun_o)
        else $error("overrun lost without a clear");
    a_ninth_checked: assert property ($rose(rx_done_flag_o) && mode_i == MODE_ASYNC8 && multiproc_check_bit_i |-> ninth_rx_bit_o)
        else $error("byte flagged with low stop under check");
    a_done_in_stop: assert property ($rose(tx_done_flag_o) && mode_i == MODE_ASYNC8
        |-> (serial_out_pin_o && tx_busy_o) [*8])
        else $error("tx done not at the stop bit");
    a_shift_clock: assert property ($fell(serial_out_pin_o) && mode_i == MODE_SYNC |-> low_half_s ##1 high_half_s)
        else $error("shift clock halves are not six cycles");
endmodule : serial_port_props
bind serial_port serial_port_props i_props (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .mode_i(mode_i), .multiproc_check_bit_i(multiproc_check_bit_i),
    .clr_tx_done_i(clr_tx_done_i), .clr_rx_done_i(clr_rx_done_i),
    .clr_overrun_i(clr_overrun_i), .irq_enable_i(irq_enable_i),
    .serial_data_buffer_o(serial_data_buffer_o), .tx_done_flag_o(tx_done_flag_o),
    .rx_done_flag_o(rx_done_flag_o), .ninth_rx_bit_o(ninth_rx_bit_o),
    .overrun_o(overrun_o), .irq_o(irq_o), .tx_busy_o(tx_busy_o),
    .serial_out_pin_o(serial_out_pin_o));
`default_nettype wire

// >>> serial_port_tb.sv
// Self-checking bench of the serial port unit
`timescale 1ns/1ps
`default_nettype none
module serial_port_tb;
    import serial_port_pkg::*;
    typedef struct packed {logic [1:0] ts; logic [1:0] rs; logic d; logic [7:0] b;} row_type;
    row_type rows [4] = '{'{2'h0, 2'h1, 1'b0, 8'hc5}, '{2'h1, 2'h0, 1'b1, 8'h3a},
                          '{2'h2, 2'h3, 1'b0, 8'h81}, '{2'h3, 2'h2, 1'b1, 8'h7e}};
    logic clk, rst_b, rx_en, mp_chk, dbl, wr_valid, irq_en, far_drive, line, oe, pin_o;
    logic out_pin, wr_ready, tx_done, rx_done, ninth, ovr, busy, irq, stop;
    logic [1:0] mode, tx_sel, rx_sel;
    logic [3:0] clr, ovf = 4'h0;
    logic [7:0] wr_data, buf_q, got, st;
    int mismatches = 0, comparisons = 0, cnt = 0, n, k;
    assign st = {tx_done, rx_done, ninth, ovr, irq, oe, out_pin, wr_ready};
    // Open drain wire with pull-up
    assign line = (oe ? pin_o : 1'b1) & far_drive;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // steady reload timers, periods 2 to 5
    always @(posedge clk) begin
        cnt <= (cnt == 59) ? 0 : cnt + 1;
        ovf <= {cnt % 5 == 0, cnt % 4 == 0, cnt % 3 == 0, cnt % 2 == 0};
    end
    serial_port i_dut (.core_clk_i(clk), .rst_b_i(rst_b), .mode_i(mode), .rx_enable_bit_i(rx_en),
        .multiproc_check_bit_i(mp_chk), .rate_double_bit_i(dbl), .tx_rate_source_sel_i(tx_sel),
        .rx_rate_source_sel_i(rx_sel), .timer_overflow_i(ovf), .wr_data_i(wr_data),
        .wr_valid_i(wr_valid), .wr_ready_o(wr_ready), .rd_strobe_i(clr[3]),
        .clr_tx_done_i(clr[2]), .clr_rx_done_i(clr[1]), .clr_overrun_i(clr[0]),
        .irq_enable_i(irq_en), .serial_data_buffer_o(buf_q), .tx_done_flag_o(tx_done),
        .rx_done_flag_o(rx_done), .ninth_rx_bit_o(ninth), .overrun_o(ovr), .tx_busy_o(busy),
        .irq_o(irq), .serial_in_pin_i(line), .serial_in_pin_o(pin_o),
        .serial_in_pin_oe_o(oe), .serial_out_pin_o(out_pin));
    far_serial_device i_far (.core_clk_i(clk), .line_i(line), .serial_out_pin_i(out_pin),
        .drive_o(far_drive));
    task automatic end_of_test();
        if (mismatches == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk8(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk8
    task automatic chk1(input logic g, input logic e);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("Error at %0t: bit %b expected %b", $time, g, e);
        end
    endtask : chk1
    // Write held until ready is seen at an edge
    task automatic put(input logic [7:0] d);
        logic took;
        wr_data <= d;
        wr_valid <= 1'b1;
        do begin
            @(negedge clk);
            took = wr_ready;
            @(posedge clk);
        end while (took !== 1'b1);
        wr_valid <= 1'b0;
    endtask : put
    // Software strobes: read, clear tx, clear rx, clear overrun
    task automatic pulse(input logic [3:0] m);
        clr <= m;
        @(posedge clk);
        clr <= 4'h0;
        @(posedge clk);
    endtask : pulse
    // cycles per bit from timer periods
    function automatic int len(input logic [1:0] s, input logic d);
        return (s == 2'h0) ? (d ? 32 : 64) : 16 * (int'(s) + 2);
    endfunction : len
    task automatic rx_byte(input logic [7:0] r, input logic s);
        i_far.send_async(r, s, len(rx_sel, dbl));
    endtask : rx_byte
    initial begin
        {rst_b, rx_en, mp_chk, dbl, wr_valid, irq_en} = 6'h00;
        {mode, tx_sel, rx_sel, clr, wr_data} = 18'h10000;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        chk8({st, buf_q}, 16'h0300);
        rx_en <= 1'b1;
        irq_en <= 1'b1;
        mp_chk <= 1'b1;
        foreach (rows[i]) begin
            {tx_sel, rx_sel, dbl} <= {rows[i].ts, rows[i].rs, rows[i].d};
            @(posedge clk);
            fork
                begin
                    put(rows[i].b);
                    i_far.recv_async(got, stop, len(tx_sel, dbl));
                end
                rx_byte(~rows[i].b, 1'b1);
            join
            chk8(got, rows[i].b);
            chk1(stop, 1'b1);
            chk8(buf_q, 8'(~rows[i].b));
            chk8(st, 8'heb);
            pulse(4'he);
            chk8(st, 8'h23);
        end
        rx_byte(8'h11, 1'b1);
        pulse(4'h2);
        rx_byte(8'h22, 1'b1);
        chk8(buf_q, 8'h22);
        chk1(ovr, 1'b1);
        pulse(4'hb);
        rx_byte(8'h33, 1'b1);
        chk1(ovr, 1'b0);
        rx_byte(8'h44, 1'b1);
        chk8(buf_q, 8'h33);
        pulse(4'ha);
        mp_chk <= 1'b1;
        rx_byte(8'h55, 1'b0);
        chk8({rx_done, buf_q}, 9'h033);
        mp_chk <= 1'b0;
        rx_byte(8'h66, 1'b0);
        chk8({rx_done, ninth, buf_q}, 10'h266);
        pulse(4'hb);
        {tx_sel, dbl, n, k} <= {3'h1, 64'h0};
        @(posedge clk);
        wr_valid <= 1'b1;
        fork
            begin
                for (int i = 0; i < 20; i++) begin
                    wr_data <= 8'(n);
                    @(negedge clk);
                    if (wr_ready === 1'b1) n++;
                    @(posedge clk);
                end
                wr_valid <= 1'b0;
            end
            do begin
                i_far.recv_async(got, stop, 32);
                chk8(got, 8'(k));
                k++;
            end while (k < n);
        join
        chk1(n == FIFO_DEPTH + 1, 1'b1);
        pulse(4'h4);
        rx_en <= 1'b0;
        mode <= MODE_SYNC;
        @(posedge clk);
        fork
            put(8'h96);
            i_far.capture_sync(got);
        join
        chk8(got, 8'h96);
        chk1(tx_done, 1'b0);
        repeat (8) @(posedge clk);
        chk1(tx_done, 1'b1);
        pulse(4'h4);
        rx_en <= 1'b1;
        i_far.shift_sync(8'h5b);
        chk8({rx_done, buf_q}, 9'h15b);
        repeat (30) @(posedge clk);
        chk8({out_pin, oe, busy, buf_q}, 11'h45b);
        rx_en <= 1'b0;
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        chk8({st, buf_q}, 16'h0300);
        // Nine-bit mode: a queued byte must not leave
        mode <= MODE_FIXED9;
        put(8'ha5);
        repeat (20) @(posedge clk);
        chk8({busy, out_pin}, 16'h0001);
        end_of_test();
    end
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        end_of_test();
    end
endmodule : serial_port_tb
`default_nettype wire
